// ==== rtl/serial_flash_command_sequencer.v ====
// Command sequencer and storage manager for the external serial flash
`default_nettype none
`include "flash_seq_map.vh"

module serial_flash_command_sequencer #(
	parameter LEN_W = 16
) (
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire             cmd_valid,
	output wire             cmd_ready,
	input  wire [2:0]       cmd_op,
	input  wire [23:0]      cmd_addr,
	input  wire [LEN_W-1:0] cmd_len,
	input  wire             cmd_raw,
	output reg              cmd_done,
	output reg              cmd_error,
	input  wire [7:0]       wr_data,
	input  wire             wr_valid,
	output wire             wr_ready,
	output reg  [7:0]       rd_data,
	output reg              rd_valid,
	output reg  [7:0]       status_byte,
	output reg  [23:0]      ident,
	input  wire             fmt_valid,
	input  wire [24:0]      fmt_size,
	output reg  [24:0]      fs_size,
	input  wire             alloc_valid,
	input  wire [24:0]      alloc_bytes,
	input  wire             alloc_secure,
	input  wire             free_valid,
	output reg              alloc_ok,
	output reg              alloc_error,
	output reg  [13:0]      alloc_blocks,
	output reg  [7:0]       file_count,
	output wire             flash_sclk,
	output reg              flash_cs_n,
	output wire             flash_mosi,
	input  wire             flash_miso
);
	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_WREN  = 4'h1;
	localparam [3:0] S_PCMD  = 4'h2;
	localparam [3:0] S_PRD   = 4'h3;
	localparam [3:0] S_GAP   = 4'h4;
	localparam [3:0] S_OP    = 4'h5;
	localparam [3:0] S_ADDR  = 4'h6;
	localparam [3:0] S_DUMMY = 4'h7;
	localparam [3:0] S_DATA  = 4'h8;

	reg  [3:0]       state_q;
	reg  [3:0]       next_q;
	reg  [2:0]       op_q;
	reg  [23:0]      addr_q;
	reg  [LEN_W-1:0] cnt_q;
	reg  [1:0]       idx_q;
	reg  [7:0]       gap_q;
	reg              wait_q;
	reg              poll_wel_q;
	reg              finish_q;
	reg  [7:0]       tx_byte;
	reg  [7:0]       opcode;
	reg              sending;
	wire             eng_busy;
	wire             eng_done;
	wire [7:0]       eng_rx;
	wire             eng_start;
	wire             is_prog;
	wire             needs_wren;
	wire             touches_array;
	wire             raw_blocked;
	wire             len_bad;
	wire             poll_ok;
	wire [12:0]      blk_raw;
	wire [13:0]      blk_plain;
	wire [13:0]      blk_secure;

	spi_byte_engine #(
		.HALF(`SCLK_HALF_CYCLES)
	) u_engine (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.start   (eng_start),
		.tx_byte (tx_byte),
		.busy    (eng_busy),
		.done    (eng_done),
		.rx_byte (eng_rx),
		.sclk    (flash_sclk),
		.mosi    (flash_mosi),
		.miso    (flash_miso)
	);

	assign cmd_ready = (state_q == S_IDLE);
	assign is_prog   = (op_q == `CMD_PROGRAM);
	assign needs_wren = (cmd_op == `CMD_PROGRAM) ||
		(cmd_op == `CMD_SECTOR_ERASE) ||
		(cmd_op == `CMD_CHIP_ERASE);
	assign touches_array = (cmd_op == `CMD_READ) || needs_wren;
	// Raw path may only reach flash above the file-system area
	assign raw_blocked = cmd_raw && touches_array &&
		(fs_size != 25'h0000000) &&
		(({1'b0, cmd_addr} < fs_size) ||
		(cmd_op == `CMD_CHIP_ERASE));
	assign len_bad = (cmd_op == `CMD_PROGRAM) &&
		((cmd_len == {LEN_W{1'b0}}) ||
		(cmd_len > `PAGE_MAX_BYTES));
	// Status polled for write enable, else for busy clear
	assign poll_ok = poll_wel_q ? eng_rx[`STAT_WEL_BIT] :
		!eng_rx[`STAT_BUSY_BIT];

	// Program bytes stall the sequence until the source offers one
	assign eng_start = sending && !wait_q && !eng_busy &&
		!(state_q == S_DATA && is_prog && !wr_valid);
	assign wr_ready = eng_start && (state_q == S_DATA) && is_prog;

	always @* begin
		case (op_q)
		`CMD_IDENT:        opcode = `OPC_IDENT;
		`CMD_STATUS:       opcode = `OPC_STATUS;
		`CMD_READ:         opcode = `OPC_READ;
		`CMD_PROGRAM:      opcode = `OPC_PROGRAM;
		`CMD_SECTOR_ERASE: opcode = `OPC_SECTOR_ERASE;
		`CMD_CHIP_ERASE:   opcode = `OPC_CHIP_ERASE;
		`CMD_PARAM_TABLE:  opcode = `OPC_PARAM_TABLE;
		default:           opcode = `OPC_STATUS;
		endcase
	end

	always @* begin
		sending = 1'b1;
		case (state_q)
		S_WREN:  tx_byte = `OPC_WREN;
		S_PCMD:  tx_byte = `OPC_STATUS;
		S_OP:    tx_byte = opcode;
		S_ADDR: begin
			case (idx_q)
			2'h2:    tx_byte = addr_q[23:16];
			2'h1:    tx_byte = addr_q[15:8];
			default: tx_byte = addr_q[7:0];
			endcase
		end
		S_DATA:  tx_byte = is_prog ? wr_data : 8'h00;
		S_PRD, S_DUMMY: tx_byte = 8'h00;
		default: begin
			tx_byte = 8'h00;
			sending = 1'b0;
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q     <= S_IDLE;
			next_q      <= S_IDLE;
			op_q        <= `CMD_STATUS;
			addr_q      <= 24'h000000;
			cnt_q       <= {LEN_W{1'b0}};
			idx_q       <= 2'h0;
			gap_q       <= 8'h00;
			wait_q      <= 1'b0;
			poll_wel_q  <= 1'b0;
			finish_q    <= 1'b0;
			flash_cs_n  <= 1'b1;
			cmd_done    <= 1'b0;
			cmd_error   <= 1'b0;
			rd_data     <= 8'h00;
			rd_valid    <= 1'b0;
			status_byte <= 8'h00;
			ident       <= 24'h000000;
		end else begin
			cmd_done  <= 1'b0;
			cmd_error <= 1'b0;
			rd_valid  <= 1'b0;
			if (eng_start)
				wait_q <= 1'b1;
			else if (eng_done)
				wait_q <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (cmd_valid) begin
					if (len_bad || raw_blocked || cmd_op > `CMD_PARAM_TABLE) begin
						cmd_error <= 1'b1;
					end else begin
						op_q       <= cmd_op;
						// Erase always takes a whole sector
						addr_q     <= (cmd_op == `CMD_SECTOR_ERASE) ?
							(cmd_addr & `SECTOR_MASK) : cmd_addr;
						cnt_q      <= cmd_len;
						idx_q      <= 2'h2;
						poll_wel_q <= needs_wren;
						flash_cs_n <= 1'b0;
						state_q    <= needs_wren ? S_WREN : S_OP;
					end
				end
			end
			S_WREN: begin
				if (eng_done) begin
					flash_cs_n <= 1'b1;
					gap_q      <= 8'h00;
					next_q     <= S_PCMD;
					state_q    <= S_GAP;
				end
			end
			S_PCMD: begin
				if (eng_done)
					state_q <= S_PRD;
			end
			S_PRD: begin
				if (eng_done) begin
					status_byte <= eng_rx;
					flash_cs_n  <= 1'b1;
					gap_q       <= 8'h00;
					state_q     <= S_GAP;
					if (!poll_ok) begin
						next_q <= S_PCMD;
					end else if (poll_wel_q) begin
						poll_wel_q <= 1'b0;
						next_q     <= S_OP;
					end else begin
						next_q   <= S_IDLE;
						finish_q <= 1'b1;
					end
				end
			end
			S_GAP: begin
				// Chip select stays high a minimum time between commands
				if (gap_q == `CS_GAP_CYCLES) begin
					state_q <= next_q;
					if (next_q == S_IDLE) begin
						cmd_done <= finish_q;
						finish_q <= 1'b0;
					end else begin
						flash_cs_n <= 1'b0;
					end
				end else begin
					gap_q <= gap_q + 8'h01;
				end
			end
			S_OP: begin
				if (eng_done) begin
					case (op_q)
					`CMD_IDENT: begin
						cnt_q   <= `ID_BYTES;
						state_q <= S_DATA;
					end
					`CMD_STATUS: begin
						cnt_q   <= {{(LEN_W-1){1'b0}}, 1'b1};
						state_q <= S_DATA;
					end
					`CMD_CHIP_ERASE: begin
						flash_cs_n <= 1'b1;
						gap_q      <= 8'h00;
						next_q     <= S_PCMD;
						state_q    <= S_GAP;
					end
					default: state_q <= S_ADDR;
					endcase
				end
			end
			S_ADDR: begin
				if (eng_done) begin
					if (idx_q != 2'h0) begin
						idx_q <= idx_q - 2'h1;
					end else if (op_q == `CMD_SECTOR_ERASE) begin
						flash_cs_n <= 1'b1;
						gap_q      <= 8'h00;
						next_q     <= S_PCMD;
						state_q    <= S_GAP;
					end else if (op_q == `CMD_PARAM_TABLE) begin
						state_q <= S_DUMMY;
					end else if (cnt_q == {LEN_W{1'b0}}) begin
						flash_cs_n <= 1'b1;
						gap_q      <= 8'h00;
						next_q     <= S_IDLE;
						finish_q   <= 1'b1;
						state_q    <= S_GAP;
					end else begin
						state_q <= S_DATA;
					end
				end
			end
			S_DUMMY: begin
				if (eng_done)
					state_q <= (cnt_q == {LEN_W{1'b0}}) ? S_GAP : S_DATA;
				if (eng_done && cnt_q == {LEN_W{1'b0}}) begin
					flash_cs_n <= 1'b1;
					gap_q      <= 8'h00;
					next_q     <= S_IDLE;
					finish_q   <= 1'b1;
				end
			end
			S_DATA: begin
				if (eng_done) begin
					cnt_q <= cnt_q - {{(LEN_W-1){1'b0}}, 1'b1};
					if (!is_prog) begin
						rd_data  <= eng_rx;
						rd_valid <= 1'b1;
					end
					if (op_q == `CMD_IDENT)
						ident <= {ident[15:0], eng_rx};
					if (op_q == `CMD_STATUS)
						status_byte <= eng_rx;
					if (cnt_q == {{(LEN_W-1){1'b0}}, 1'b1}) begin
						flash_cs_n <= 1'b1;
						gap_q      <= 8'h00;
						state_q    <= S_GAP;
						if (is_prog) begin
							next_q <= S_PCMD;
						end else begin
							next_q   <= S_IDLE;
							finish_q <= 1'b1;
						end
					end
				end
			end
			default: begin
				state_q    <= S_IDLE;
				flash_cs_n <= 1'b1;
			end
			endcase
		end
	end

	// Space accounting for the file system
	assign blk_raw = alloc_bytes[24:12] +
		{12'h000, (alloc_bytes[11:0] != 12'h000)};
	assign blk_plain  = (blk_raw == 13'h0000) ? 14'h0001 : {1'b0, blk_raw};
	assign blk_secure = ({blk_plain[12:0], 1'b0} < `SECURE_MIN_BLKS) ?
		`SECURE_MIN_BLKS : {blk_plain[12:0], 1'b0};

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			fs_size      <= 25'h0000000;
			alloc_ok     <= 1'b0;
			alloc_error  <= 1'b0;
			alloc_blocks <= 14'h0000;
			file_count   <= 8'h00;
		end else begin
			alloc_ok    <= 1'b0;
			alloc_error <= 1'b0;
			// Only the size is set; the area always starts at zero
			if (fmt_valid) begin
				fs_size    <= fmt_size;
				file_count <= 8'h00;
			end else if (alloc_valid) begin
				if (file_count >= `MAX_FILES ||
					alloc_bytes > `MAX_FILE_BYTES) begin
					alloc_error <= 1'b1;
				end else begin
					alloc_ok     <= 1'b1;
					file_count   <= file_count + 8'h01;
					alloc_blocks <= alloc_secure ? blk_secure : blk_plain;
				end
			end else if (free_valid && file_count != 8'h00) begin
				file_count <= file_count - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/flash_seq_map.vh ====
// Constants for the serial flash command sequencer
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

`define OPC_IDENT        8'h9F
`define OPC_STATUS       8'h05
`define OPC_WREN         8'h06
`define OPC_CHIP_ERASE   8'hC7
`define OPC_READ         8'h03
`define OPC_PROGRAM      8'h02
`define OPC_SECTOR_ERASE 8'h20
`define OPC_PARAM_TABLE  8'h5A

`define CMD_IDENT        3'h0
`define CMD_STATUS       3'h1
`define CMD_READ         3'h2
`define CMD_PROGRAM      3'h3
`define CMD_SECTOR_ERASE 3'h4
`define CMD_CHIP_ERASE   3'h5
`define CMD_PARAM_TABLE  3'h6

`define STAT_BUSY_BIT    0
`define STAT_WEL_BIT     1
`define ID_BYTES         16'h0003
`define PAGE_MAX_BYTES   16'h00FF
`define SECTOR_MASK      24'hFFF000
`define BLOCK_SHIFT      12
`define MAX_FILES        8'h80
`define MAX_FILE_BYTES   25'h1000000
`define SECURE_MIN_BLKS  14'h0002

`define SCLK_HALF_CYCLES 4
`define CS_GAP_CYCLES    8'h04

`endif

// ==== rtl/spi_byte_engine.v ====
// One-byte SPI mode 0 shifter with input synchroniser
`default_nettype none
`include "flash_seq_map.vh"

module spi_byte_engine #(
	parameter HALF = `SCLK_HALF_CYCLES
) (
	input  wire       clk_sys,
	input  wire       sys_rst,
	input  wire       start,
	input  wire [7:0] tx_byte,
	output wire       busy,
	output reg        done,
	output reg  [7:0] rx_byte,
	output reg        sclk,
	output wire       mosi,
	input  wire       miso
);
	localparam integer HALF_M1  = HALF - 1;
	localparam [7:0]   HALF_END = HALF_M1[7:0];

	reg       busy_q;
	reg [2:0] bit_q;
	reg [7:0] cnt_q;
	reg [7:0] sh_q;
	reg [7:0] rx_q;
	reg       miso_m_q;
	reg       miso_s_q;

	assign busy = busy_q;
	assign mosi = sh_q[7];

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_q   <= 1'b0;
			bit_q    <= 3'h0;
			cnt_q    <= 8'h00;
			sh_q     <= 8'h00;
			rx_q     <= 8'h00;
			rx_byte  <= 8'h00;
			done     <= 1'b0;
			sclk     <= 1'b0;
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end else begin
			done     <= 1'b0;
			miso_m_q <= miso;
			miso_s_q <= miso_m_q;
			if (!busy_q) begin
				if (start) begin
					busy_q <= 1'b1;
					sh_q   <= tx_byte;
					bit_q  <= 3'h7;
					cnt_q  <= 8'h00;
				end
			end else if (cnt_q == HALF_END) begin
				cnt_q <= 8'h00;
				if (!sclk) begin
					// Sample on rising edge, data has had a half period
					sclk <= 1'b1;
					rx_q <= {rx_q[6:0], miso_s_q};
				end else begin
					sclk <= 1'b0;
					sh_q <= {sh_q[6:0], 1'b0};
					if (bit_q == 3'h0) begin
						busy_q  <= 1'b0;
						done    <= 1'b1;
						rx_byte <= rx_q;
					end else begin
						bit_q <= bit_q - 3'h1;
					end
				end
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/flash_model.sv ====
// Behavioural serial flash on the far side of the sequencer
`default_nettype none
module flash_model #(
	parameter logic [23:0] ID_CODE    = 24'h5A3C96, // Arbitrary value
	parameter int          BUSY_POLLS = 3
) (
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	output var  logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [int];
	logic [7:0]  sr, nxt, op;
	logic [7:0]  out = 8'h00;
	logic [23:0] a;
	int          cnt, bi, busy, wel, welp, viol, nstat;
	function automatic logic [7:0] rd(input int x);
		return mem.exists(x) ? mem[x] : 8'hFF;
	endfunction
	// Deselected line shows the inverse so a stale sample cannot match
	assign miso = cs_n ? ~out[7] : out[7];
	always @(negedge cs_n) begin
		cnt = 0;
		bi = 0;
	end
	always @(negedge sclk) out = (cnt == 0) ? nxt : {out[6:0], 1'h1};
	always @(posedge sclk) begin
		sr = {sr[6:0], mosi};
		cnt++;
		if (cnt == 8) begin
			cnt = 0;
			if (bi == 0) op = sr;
			else if (bi < 4) a = {a[15:0], sr};
			else if (op == 8'h02) mem[a + bi - 4] = sr;
			case (op)
			8'h9F: nxt = bi < 3 ? 8'(ID_CODE >> (16 - 8 * bi)) : 8'hFF;
			8'h05: nxt = {6'h00, wel == 1, busy != 0};
			8'h03: nxt = bi >= 3 ? rd(a + bi - 3) : 8'hFF;
			8'h5A: nxt = 8'hC3;
			default: nxt = 8'hFF;
			endcase
			bi++;
		end
	end
	// Latch sets only after one status read, so a sequencer must poll
	always @(posedge cs_n) begin
		if (op == 8'h05) begin
			nstat++;
			if (busy > 0) busy--;
			if (welp != 0) wel = 1;
			welp = 0;
		end else if (op == 8'h06) welp = 1;
		else if (op inside {8'h02, 8'h20, 8'hC7}) begin
			if (wel == 0) viol++;
			if (op == 8'h02 && (bi < 5 || bi > 259)) viol++;
			if (op == 8'h20)
				for (int i = 0; i < 4096; i++)
					mem.delete({a[23:12], 12'h000} + i);
			if (op == 8'hC7) mem.delete();
			busy = BUSY_POLLS;
			wel = 0;
		end
	end
endmodule
`default_nettype wire

// ==== bench/serial_flash_command_sequencer_props.sv ====
// Port assertions for the serial flash command sequencer
`default_nettype none
`include "flash_seq_map.vh"
module serial_flash_command_sequencer_props #(
	parameter LEN_W = 16
) (
	input wire logic             clk_sys,
	input wire logic             sys_rst,
	input wire logic             cmd_valid,
	input wire logic             cmd_ready,
	input wire logic [2:0]       cmd_op,
	input wire logic [23:0]      cmd_addr,
	input wire logic [LEN_W-1:0] cmd_len,
	input wire logic             cmd_raw,
	input wire logic             cmd_done,
	input wire logic             cmd_error,
	input wire logic             fmt_valid,
	input wire logic [24:0]      fmt_size,
	input wire logic [24:0]      fs_size,
	input wire logic             alloc_valid,
	input wire logic [24:0]      alloc_bytes,
	input wire logic             alloc_secure,
	input wire logic             alloc_ok,
	input wire logic             alloc_error,
	input wire logic [13:0]      alloc_blocks,
	input wire logic [7:0]       file_count,
	input wire logic             flash_sclk,
	input wire logic             flash_cs_n,
	input wire logic             flash_mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic acc;
	assign acc = cmd_valid && cmd_ready;
	function automatic logic [13:0] blk(input logic [24:0] b);
		logic [24:0] q;
		q = (b + 25'h0000FFF) >> 12;
		return (q == 25'h0) ? 14'h0001 : q[13:0];
	endfunction
	a_sclk_idle_low: assert property (flash_cs_n |-> !flash_sclk)
		else $error("sclk high while deselected");
	a_mosi_held: assert property (flash_sclk && $past(flash_sclk) |->
		$stable(flash_mosi)) else $error("mosi moved while sclk high");
	a_sclk_half: assert property ($rose(flash_sclk) |->
		flash_sclk[*4] ##1 !flash_sclk) else $error("sclk high phase");
	a_cs_in_cmd: assert property (!flash_cs_n |-> !cmd_ready)
		else $error("chip select low outside a command");
	a_page_len: assert property (acc && cmd_op == `CMD_PROGRAM &&
		(cmd_len == 0 || cmd_len > `PAGE_MAX_BYTES) |=> cmd_error &&
		flash_cs_n) else $error("bad page length accepted");
	a_raw_guard: assert property (acc && cmd_raw &&
		cmd_op == `CMD_READ && fs_size != 0 && cmd_addr < fs_size
		|=> cmd_error) else $error("raw access to file area");
	a_file_limit: assert property (alloc_valid && !fmt_valid &&
		file_count >= 8'h80 |=> alloc_error && !alloc_ok)
		else $error("file count limit");
	a_size_limit: assert property (alloc_valid && !fmt_valid &&
		alloc_bytes > 25'h1000000 |=> alloc_error) else $error("file too big");
	a_whole_blocks: assert property (alloc_ok && !$past(alloc_secure)
		|-> alloc_blocks == blk($past(alloc_bytes))) else $error("block count");
	a_secure_blocks: assert property (alloc_ok && $past(alloc_secure)
		|-> alloc_blocks == 14'(2 * blk($past(alloc_bytes))))
		else $error("secure block count");
	a_fmt_base: assert property (fmt_valid |=>
		fs_size == $past(fmt_size) && file_count == 8'h00)
		else $error("format result");
	c_done: cover property (cmd_done);
	c_error: cover property (cmd_error);
	c_alloc_err: cover property (alloc_error);
	c_multi_blk: cover property (alloc_ok && alloc_blocks > 14'h0001);
endmodule
bind serial_flash_command_sequencer serial_flash_command_sequencer_props
	#(.LEN_W(LEN_W)) u_props (.*);
`default_nettype wire

// ==== bench/serial_flash_command_sequencer_tb_top.sv ====
// Self-checking bench for the serial flash command sequencer
`default_nettype none
`include "flash_seq_map.vh"
module serial_flash_command_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] ID = 24'h5A3C96; // Arbitrary value
	logic        clk_sys = 1'h0, sys_rst = 1'h1, cmd_valid = 1'h0;
	logic        cmd_raw = 1'h0, wr_valid = 1'h0, fmt_valid = 1'h0;
	logic        alloc_valid = 1'h0, alloc_secure = 1'h0, free_valid = 1'h0;
	logic [2:0]  cmd_op = 3'h0;
	logic [23:0] cmd_addr = 24'h0, ident;
	logic [15:0] cmd_len = 16'h0;
	logic [7:0]  wr_data = 8'h0, rd_data, status_byte, file_count;
	logic [24:0] fmt_size = 25'h0, alloc_bytes = 25'h0, fs_size;
	logic [13:0] alloc_blocks;
	logic        cmd_ready, cmd_done, cmd_error, wr_ready, rd_valid;
	logic        alloc_ok, alloc_error, flash_sclk, flash_cs_n;
	logic        flash_mosi, flash_miso;
	logic [7:0]  wb [256], rb [256];
	int          err_count = 0, checked = 0, k, nrd, fin, tk;
	serial_flash_command_sequencer dut (.*);
	flash_model #(.ID_CODE(ID)) flash (.sclk(flash_sclk),
		.cs_n(flash_cs_n), .mosi(flash_mosi), .miso(flash_miso));
	initial forever #10 clk_sys = ~clk_sys;
	task automatic complete_run;
		if (err_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic cmd(input logic [2:0] op, input logic [23:0] a,
		input logic [15:0] n, input logic r);
		cmd_op = op;
		cmd_addr = a;
		cmd_len = n;
		cmd_raw = r;
		cmd_valid = 1'h1;
		wr_valid = op == `CMD_PROGRAM;
		wr_data = wb[0];
		k = 0;
		nrd = 0;
		fin = 0;
		flash.nstat = 0;
		@(posedge clk_sys);
		#1 cmd_valid = 1'h0;
		// Outputs are read a step after the edge, where they have settled
		for (int i = 0; i < 90000 && fin == 0; i++) begin
			if (rd_valid === 1'h1) rb[nrd++] = rd_data;
			if (cmd_done === 1'h1) fin = 1;
			if (cmd_error === 1'h1) fin = 2;
			tk = (wr_ready === 1'h1);
			@(posedge clk_sys);
			#1;
			// Byte was taken at this edge, offer the next one
			if (tk != 0) wr_data = wb[++k];
		end
		// Erase polls have no bound of their own
		if (fin == 0) begin
			chk("cmd finish", 1, 0);
			complete_run();
		end
	endtask
	task automatic fmt(input logic [24:0] s);
		fmt_size = s;
		fmt_valid = 1'h1;
		@(posedge clk_sys);
		#1 fmt_valid = 1'h0;
	endtask
	task automatic alc(input logic [24:0] b, input logic s, input logic e,
		input logic [13:0] n);
		alloc_bytes = b;
		alloc_secure = s;
		alloc_valid = 1'h1;
		@(posedge clk_sys);
		#1 alloc_valid = 1'h0;
		chk("alloc_ok", e, alloc_ok);
		chk("alloc_error", !e, alloc_error);
		if (e) chk("alloc_blocks", n, alloc_blocks);
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_ident;
		cmd(`CMD_IDENT, 24'h0, 16'h0, 1'h0);
		chk("ident", ID, ident);
		chk("ident bytes", 3, nrd);
		// Flash left busy so the status byte is not all zeros
		flash.busy = 1;
		cmd(`CMD_STATUS, 24'h0, 16'h0, 1'h0);
		chk("status reads", 1, nrd);
		chk("status data", 8'h01, rb[0]);
		chk("status busy", 8'h01, status_byte);
		chk("status polls", 1, flash.nstat);
	endtask
	task automatic t_prog;
		wb[0] = 8'hA5;
		wb[1] = 8'h5A;
		wb[2] = 8'h81;
		cmd(`CMD_PROGRAM, 24'h001FFE, 16'h0003, 1'h0);
		chk("program polls", 6, flash.nstat);
		chk("program order", 0, flash.viol);
		chk("status_byte", 8'h00, status_byte);
		cmd(`CMD_READ, 24'h001FFE, 16'h0004, 1'h0);
		chk("read data", 32'hA55A81FF, {rb[0], rb[1], rb[2], rb[3]});
	endtask
	task automatic t_erase;
		cmd(`CMD_SECTOR_ERASE, 24'h001234, 16'h0, 1'h0);
		chk("erase polls", 6, flash.nstat);
		cmd(`CMD_READ, 24'h001FFE, 16'h0003, 1'h0);
		chk("sector span", 24'hFFFF81, {rb[0], rb[1], rb[2]});
		cmd(`CMD_CHIP_ERASE, 24'h0, 16'h0, 1'h0);
		chk("chip polls", 6, flash.nstat);
		chk("erase order", 0, flash.viol);
		cmd(`CMD_READ, 24'h002000, 16'h0001, 1'h0);
		chk("chip erased", 8'hFF, rb[0]);
		cmd(`CMD_PARAM_TABLE, 24'h0, 16'h0002, 1'h0);
		chk("param bytes", 16'hC3C3, {rb[0], rb[1]});
	endtask
	task automatic t_refuse;
		cmd(`CMD_PROGRAM, 24'h0, 16'h0000, 1'h0);
		chk("len zero", 2, fin);
		cmd(`CMD_PROGRAM, 24'h0, 16'h0100, 1'h0);
		chk("len 256", 2, fin);
		cmd(3'h7, 24'h0, 16'h0, 1'h0);
		chk("bad op", 2, fin);
		fmt(25'h0002000);
		cmd(`CMD_READ, 24'h001FFF, 16'h0001, 1'h1);
		chk("raw in fs", 2, fin);
		cmd(`CMD_READ, 24'h002000, 16'h0001, 1'h1);
		chk("raw past fs", 1, fin);
		cmd(`CMD_CHIP_ERASE, 24'h0, 16'h0, 1'h1);
		chk("raw chip erase", 2, fin);
	endtask
	task automatic t_alloc;
		fmt(25'h0100000);
		chk("fs_size", 25'h0100000, fs_size);
		alc(25'h0000001, 1'h0, 1'h1, 14'h0001);
		alc(25'h0001000, 1'h0, 1'h1, 14'h0001);
		alc(25'h0001001, 1'h0, 1'h1, 14'h0002);
		alc(25'h0000001, 1'h1, 1'h1, 14'h0002);
		alc(25'h0002001, 1'h1, 1'h1, 14'h0006);
		alc(25'h1000000, 1'h0, 1'h1, 14'h1000);
		alc(25'h1000001, 1'h0, 1'h0, 14'h0000);
		repeat (122) alc(25'h0000001, 1'h0, 1'h1, 14'h0001);
		chk("file_count", 8'h80, file_count);
		alc(25'h0000001, 1'h0, 1'h0, 14'h0000);
		free_valid = 1'h1;
		@(posedge clk_sys);
		#1 free_valid = 1'h0;
		alc(25'h0000001, 1'h0, 1'h1, 14'h0001);
	endtask
	initial begin
		#2000000;
		$display("[FAIL] watchdog expected finish seen timeout");
		err_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 sys_rst = 1'h0;
		@(posedge clk_sys);
		#1;
		t_ident();
		t_prog();
		t_erase();
		t_refuse();
		t_alloc();
		complete_run();
	end
endmodule
`default_nettype wire
